// ---- rtl/csm_consts.vh ----
// constants for the comma segment multiplexer
// assumes a 250 MHz clk; times are given in ns and converted to cycles
`ifndef CSM_CONSTS_VH
`define CSM_CONSTS_VH
`define CSM_COMMA_RAM_ADDR 5'h0C
`define CSM_COMMA_SCAN_CODE 4'h6
`define CSM_CLK_PERIOD_NS 4
`define CSM_MTP_TIME_NS 62500
`define CSM_SLOT_TIME_NS 500000
`define CSM_CAPTURE_TIME_NS 30000
`define CSM_MTP_CYCLES (`CSM_MTP_TIME_NS / `CSM_CLK_PERIOD_NS)
`define CSM_SLOT_CYCLES (`CSM_SLOT_TIME_NS / `CSM_CLK_PERIOD_NS)
`define CSM_CAPTURE_CYCLES \
  ((`CSM_CAPTURE_TIME_NS + `CSM_CLK_PERIOD_NS - 1) / `CSM_CLK_PERIOD_NS)
`define CSM_BLOCK_CYCLES (`CSM_SLOT_CYCLES)
`define CSM_COMMA_RESET 8'h00
`define CSM_ENABLE_RESET 1'b0
`endif

// ---- rtl/csm_comma_selector.v ----
// 8-into-1 selector picking the comma bit of the active block
// assumes the select code is the low three bits of the block scan count
module csm_comma_selector #(
  parameter WIDTH = 8,
  parameter SEL_W = 3
) (
  input wire [WIDTH-1:0] data_in,
  input wire [SEL_W-1:0] sel,
  output wire bit_out
);
  assign bit_out = data_in[sel];
endmodule // csm_comma_selector

// ---- rtl/csm_comma_segment_multiplexer.v ----
// comma segment drive for a two-display multiplexed block scan
// assumes synchronous inputs, one clock, RAM data bus driven externally
//
// What this block does
// [R1] commas share one RAM byte at 01100
// [R2] seven blocks (codes 0-5 and 7) have commas, others none
// [R3] scan 0110 fetches comma byte, section low
// [R4] code 0110 drives low comma strobe
// [R5] comma byte blanked from ordinary segments
// [R6] strobe edge captures byte after 30us
// [R7] captured byte held until next strobe
// [R8] scan count selects active block's comma bit
// [R9] comma off during strobe and blanking
// [R10] gated comma drives primary display
// [R11] segments forced low at block changeover
// [R12] both displays' anodes energized together
// [R13] controller pulses mode line to set latch
// [R14] enable latch takes address bit zero
// [R15] enabled latch copies commas to second display
// [R16] cleared latch blocks second display commas
// [R17] master timing pulse lasts 62.5us
// [R18] reset clears enable latch and comma byte
`include "csm_consts.vh"
module csm_comma_segment_multiplexer #(
  parameter MTP_CYCLES = `CSM_MTP_CYCLES,
  parameter BLOCK_CYCLES = `CSM_BLOCK_CYCLES,
  parameter CAPTURE_CYCLES = `CSM_CAPTURE_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire [7:0] ram_data,
  input wire [7:0] output_seg_in,
  input wire [7:0] mode_seg_in,
  input wire mode_comma_ctrl_n,
  input wire address_bit_zero,
  output reg [3:0] block_scan_counter,
  output reg [4:0] ram_addr,
  output reg ram_section_select,
  output reg comma_slot_strobe_n,
  output reg master_timing_pulse,
  output reg [11:0] anode_enable,
  output reg [7:0] output_seg_drive,
  output reg [7:0] mode_seg_drive,
  output reg output_comma_drive,
  output reg mode_comma_drive,
  output reg mode_comma_enable_latch,
  output reg [7:0] comma_byte_latch
);
  // scan sequence covers codes 0..12 (blocks plus comma slot)
  localparam [3:0] LAST_CODE = 4'hC;
  localparam integer BLOCK_LAST_I = BLOCK_CYCLES - 1;
  localparam integer MTP_LAST_I = MTP_CYCLES - 1;
  localparam integer CAP_AT_I = CAPTURE_CYCLES;
  // an 18-bit tick covers the full block time at 4 ns; longer blocks
  // would need a wider tick
  localparam [17:0] BLOCK_LAST = BLOCK_LAST_I[17:0];
  localparam [17:0] MTP_LAST = MTP_LAST_I[17:0];
  localparam [17:0] CAP_AT = CAP_AT_I[17:0];

  reg [17:0] tick_reg;
  reg [17:0] tick_next;
  reg [3:0] scan_next;
  reg cap_done_reg;
  reg load_pulse_n_reg;
  reg load_pulse_n_next;
  wire mtp_now;
  wire comma_slot;
  wire blank_now;
  wire comma_sel_bit;
  wire gated_comma;
  wire capture_now;
  wire [11:0] anode_code;

  function [11:0] anode_decode;
    input [3:0] code;
    begin
      anode_decode = 12'h000;
      if (code < 4'hC && code != `CSM_COMMA_SCAN_CODE) begin
        anode_decode[code] = 1'b1;
      end
    end
  endfunction

  // blanking window shared by segments, commas and section select
  function blank_decode;
    input mtp;
    input slot;
    begin
      blank_decode = mtp || slot;
    end
  endfunction

  assign mtp_now = (tick_reg <= MTP_LAST); // [R17]
  assign comma_slot = (block_scan_counter == `CSM_COMMA_SCAN_CODE); // [R4]
  assign blank_now = blank_decode(mtp_now, comma_slot); // [R5] [R11]
  assign anode_code = anode_decode(block_scan_counter); // [R12]

  always @* begin
    tick_next = tick_reg + 18'h00001;
    if (tick_reg == BLOCK_LAST) begin
      tick_next = 18'h00000;
    end
  end

  always @* begin
    scan_next = block_scan_counter;
    if (tick_reg == BLOCK_LAST) begin
      if (block_scan_counter == LAST_CODE) begin
        scan_next = 4'h0;
      end else begin
        scan_next = block_scan_counter + 4'h1;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_reg <= 18'h00000;
    end else begin
      tick_reg <= tick_next;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      block_scan_counter <= 4'h0;
    end else begin
      block_scan_counter <= scan_next; // [R3]
    end
  end

  // load pulse: low from the start of the comma slot to the capture point;
  // a capture delay of zero never opens it, so no byte would be taken
  always @* begin
    load_pulse_n_next = 1'b1;
    if (comma_slot && !cap_done_reg && tick_reg < CAP_AT) begin
      load_pulse_n_next = 1'b0;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_pulse_n_reg <= 1'b1;
    end else begin
      load_pulse_n_reg <= load_pulse_n_next;
    end
  end

  // the rising edge of the load pulse takes the byte off the bus, well
  // after the fetch address has settled on the ram
  assign capture_now = !load_pulse_n_reg && load_pulse_n_next; // [R6]

  // one capture per slot, so a late bus glitch cannot reload the byte
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_done_reg <= 1'b0;
    end else if (!comma_slot) begin
      cap_done_reg <= 1'b0;
    end else if (capture_now) begin
      cap_done_reg <= 1'b1;
    end
  end

  // comma byte held until the next capture
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      comma_byte_latch <= `CSM_COMMA_RESET; // [R18]
    end else if (capture_now) begin
      comma_byte_latch <= ram_data; // [R6] [R7]
    end
  end

  // mode comma latch follows address bit while the line is low
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_comma_enable_latch <= `CSM_ENABLE_RESET; // [R18]
    end else if (!mode_comma_ctrl_n) begin
      mode_comma_enable_latch <= address_bit_zero; // [R13] [R14]
    end
  end

  // low three bits select the block; only blocks 0..7 carry commas
  csm_comma_selector #(
    .WIDTH(8),
    .SEL_W(3)
  ) u_sel (
    .data_in(comma_byte_latch),
    .sel(block_scan_counter[2:0]),
    .bit_out(comma_sel_bit)
  ); // [R8]

  assign gated_comma = comma_sel_bit && !blank_decode(mtp_now, comma_slot) &&
                       !block_scan_counter[3]; // [R2] [R9]

  // registered so the front drivers never see decode glitches
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      master_timing_pulse <= 1'b0;
    end else begin
      master_timing_pulse <= mtp_now; // [R17]
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      comma_slot_strobe_n <= 1'b1;
    end else begin
      comma_slot_strobe_n <= !comma_slot; // [R4]
    end
  end

  // section low during the pulse and the whole comma slot
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_section_select <= 1'b0;
    end else begin
      ram_section_select <= !blank_now; // [R3]
    end
  end

  // the comma slot overrides the block address for its whole length
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_addr <= 5'h00;
    end else begin
      if (comma_slot) begin
        ram_addr <= `CSM_COMMA_RAM_ADDR; // [R1] [R3]
      end else begin
        ram_addr <= {!mtp_now, block_scan_counter};
      end
    end
  end

  // per-anode flip-flops so every output comes straight from a register
  genvar an_i;
  generate
    for (an_i = 0; an_i < 12; an_i = an_i + 1) begin : g_anode
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          anode_enable[an_i] <= 1'b0;
        end else begin
          anode_enable[an_i] <= anode_code[an_i]; // [R12]
        end
      end
    end
  endgenerate

  // primary display segments, dark at every changeover
  genvar os_i;
  generate
    for (os_i = 0; os_i < 8; os_i = os_i + 1) begin : g_oseg
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          output_seg_drive[os_i] <= 1'b0;
        end else if (blank_now) begin
          output_seg_drive[os_i] <= 1'b0; // [R5] [R11]
        end else begin
          output_seg_drive[os_i] <= output_seg_in[os_i]; // [R12]
        end
      end
    end
  endgenerate

  // second display segments share the same blanking window
  genvar ms_i;
  generate
    for (ms_i = 0; ms_i < 8; ms_i = ms_i + 1) begin : g_mseg
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mode_seg_drive[ms_i] <= 1'b0;
        end else if (blank_now) begin
          mode_seg_drive[ms_i] <= 1'b0; // [R5] [R11]
        end else begin
          mode_seg_drive[ms_i] <= mode_seg_in[ms_i]; // [R12]
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_comma_drive <= 1'b0;
    end else begin
      output_comma_drive <= gated_comma; // [R10]
    end
  end

  // the copy uses the same gated stream, so with the latch set both displays agree per block
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_comma_drive <= 1'b0;
    end else begin
      mode_comma_drive <= gated_comma && mode_comma_enable_latch; // [R15] [R16]
    end
  end
endmodule // csm_comma_segment_multiplexer

// ---- verification/csm_ram_model.sv ----
// display ram seen from the scan side: comma byte at its slot
// assumes the bench loads the comma byte as the cpu would
module csm_ram_model (
  input wire logic [4:0] ram_addr,
  input wire logic ram_section_select,
  input wire logic [7:0] comma,
  output wire logic [7:0] ram_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // other addresses show the inverse so a wrong fetch cannot match
  assign ram_data = (ram_addr == 5'h0C && !ram_section_select) ?
    comma : ~comma;
endmodule // csm_ram_model

// ---- verification/csm_asserts.sv ----
// port checker for the comma segment multiplexer
// assumes the bench runs MTP_CYCLES at 4
module csm_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mode_comma_ctrl_n,
  input wire logic address_bit_zero,
  input wire logic [3:0] block_scan_counter,
  input wire logic [4:0] ram_addr,
  input wire logic ram_section_select,
  input wire logic comma_slot_strobe_n,
  input wire logic master_timing_pulse,
  input wire logic [11:0] anode_enable,
  input wire logic [7:0] output_seg_drive,
  input wire logic output_comma_drive,
  input wire logic mode_comma_drive,
  input wire logic mode_comma_enable_latch,
  input wire logic [7:0] comma_byte_latch
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_FETCH: assert property (!comma_slot_strobe_n |->
    ram_addr == 5'h0C && !ram_section_select) else $error("bad fetch");
  AST_ANODE: assert property (!comma_slot_strobe_n |->
    anode_enable == 0) else $error("anode in slot");
  AST_MTP: assert property ($rose(master_timing_pulse) |->
    master_timing_pulse [*4] ##1 !master_timing_pulse)
    else $error("pulse length");
  AST_BLANK: assert property (master_timing_pulse |->
    output_seg_drive == 0 && !output_comma_drive)
    else $error("not blanked");
  AST_HOLD: assert property (comma_slot_strobe_n &&
    $past(comma_slot_strobe_n) |-> $stable(comma_byte_latch))
    else $error("byte moved");
  AST_NO9: assert property (block_scan_counter > 4'h7 &&
    $past(block_scan_counter) > 4'h7 |-> !output_comma_drive)
    else $error("comma on block 8+");
  AST_LOAD: assert property (!mode_comma_ctrl_n |=>
    mode_comma_enable_latch == $past(address_bit_zero))
    else $error("latch load");
  AST_KEEP: assert property (mode_comma_ctrl_n |=>
    $stable(mode_comma_enable_latch)) else $error("latch drift");
  AST_COPY: assert property (mode_comma_enable_latch ##1 1 |->
    mode_comma_drive == output_comma_drive) else $error("no copy");
  AST_OFF: assert property (!mode_comma_enable_latch ##1 1 |->
    !mode_comma_drive) else $error("mode comma leak");
  COV_SLOT: cover property ($fell(comma_slot_strobe_n));
  COV_COMMA: cover property (output_comma_drive);
  COV_COPY: cover property (mode_comma_drive);
endmodule // csm_asserts
bind csm_comma_segment_multiplexer csm_asserts i_chk (.*);

// ---- verification/tb.sv ----
// self-checking bench for the comma segment multiplexer
// assumes small timing parameters so a full scan is 208 cycles
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, ctrl_n = 1, a0 = 0, en;
  logic [7:0] comma = 8'h00, oseg = 8'h00, mseg = 8'h00, last, cbl;
  logic [7:0] q[$];
  logic [4:0] addr;
  wire logic sec;
  wire logic [7:0] rd;
  wire logic [11:0] an;
  wire logic mtp, stb_n, oc, mc;
  wire logic [7:0] osd, msd;
  logic [7:0] oseg_q, mseg_q, cbl_q, e;
  logic en_q, live = 0;
  int miscompares = 0, samples_checked = 0, cyc = 0;
  csm_ram_model i_ram (.ram_addr(addr), .ram_section_select(sec),
    .comma(comma), .ram_data(rd));
  csm_comma_segment_multiplexer #(.MTP_CYCLES(4), .BLOCK_CYCLES(16),
    .CAPTURE_CYCLES(6)) i_dut (.clk(clk), .rst_n(rst_n), .ram_data(rd),
    .output_seg_in(oseg), .mode_seg_in(mseg), .mode_comma_ctrl_n(ctrl_n),
    .address_bit_zero(a0), .block_scan_counter(), .ram_addr(addr),
    .ram_section_select(sec), .comma_slot_strobe_n(stb_n),
    .master_timing_pulse(mtp), .anode_enable(an), .output_seg_drive(osd),
    .mode_seg_drive(msd), .output_comma_drive(oc), .mode_comma_drive(mc),
    .mode_comma_enable_latch(en), .comma_byte_latch(cbl));
  initial forever #2 clk = ~clk;
  task chk(input logic [7:0] seen, input logic [7:0] exp, input string n);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task finish_test;
    $display("checked %0d failed %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      finish_test;
    end
  end
  // inputs and state as the design sampled them at the last rising edge
  always @(posedge clk) begin
    live <= rst_n;
    oseg_q <= oseg;
    mseg_q <= mseg;
    cbl_q <= cbl;
    en_q <= en;
  end
  // drives settle between edges; expected from the energized anode
  always @(negedge clk) if (live && rst_n) begin
    e = 8'h00;
    for (int k = 0; k < 8; k++) if (an[k]) e = {7'h00, cbl_q[k]};
    if (mtp || !stb_n) e = 8'h00;
    chk({7'h00, oc}, e, "output comma");
    chk({7'h00, mc}, e & {7'h00, en_q}, "mode comma");
    chk(osd, (mtp || !stb_n) ? 8'h00 : oseg_q, "output segs");
    chk(msd, (mtp || !stb_n) ? 8'h00 : mseg_q, "mode segs");
  end
  // each captured byte must be the oldest one the cpu wrote
  always @(cbl) if (rst_n) begin
    chk(cbl, q.size() ? q.pop_front() : ~cbl, "comma byte");
  end
  initial begin
    last = $urandom(32'hBA2A);
    repeat (20) @(negedge clk);
    chk(cbl, 8'h00, "reset byte");
    chk({7'h00, en}, 8'h00, "reset latch");
    rst_n = 1;
    for (int i = 0; i < 6; i++) begin
      // a fresh byte every round so every capture shows as a change
      comma = last ^ (8'($urandom % 255) + 8'h01);
      last = comma;
      q.push_back(comma);
      oseg = $urandom;
      mseg = $urandom;
      a0 = $urandom;
      ctrl_n = 0;
      @(negedge clk);
      ctrl_n = 1;
      chk({7'h00, en}, {7'h00, a0}, "enable latch");
      repeat (220) @(negedge clk);
    end
    chk(8'(q.size()), 8'h00, "pending bytes");
    finish_test;
  end
endmodule // tb
